// [bench/sarseq_core_model.sv]
// behavioural model of multiplexer and comparator
`timescale 1ns/1ps
`default_nettype none
module sarseq_core_model (
  input  wire logic                       clk_i,
  input  wire sarseq_pkg::sarseq_analog_t analog_i,
  input  wire logic signed [11:0]         vin_i [sarseq_pkg::NUM_CHAN],
  output logic                            comparator_o
);
  import sarseq_pkg::*;
  logic idle_reg = 1'b0;
  logic hit;

  // undriven comparator wanders instead of holding its last answer
  always @(posedge clk_i) begin
    idle_reg <= ~idle_reg;
  end

  assign hit = analog_i.core_en && analog_i.mux_en && (analog_i.mux_sel < 4'hC);

  always_comb begin
    if (hit) begin
      comparator_o = ($signed({2'b00, analog_i.trial}) <= vin_i[analog_i.mux_sel]);
    end else begin
      comparator_o = idle_reg;
    end
  end
endmodule
`default_nettype wire

// [bench/test_sarseq_top.sv]
// self-checking testbench of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module test_sarseq_top;
  import sarseq_pkg::*;
  logic                 clk_i                  = 1'b0;
  logic                 rst_i                  = 1'b1;
  logic                 start_wr_i             = 1'b0;
  logic                 pwm_trigger_i          = 1'b0;
  logic                 converter_enable_bit_i = 1'b1;
  logic                 reference_enable_bit_i = 1'b0;
  logic                 convert_on_read_bit_i  = 1'b0;
  logic                 channel_wr_i           = 1'b0;
  logic [CHAN_W-1:0]    channel_data_i         = 4'h0;
  logic [CHAN_W-1:0]    max_channel_i          = 4'hB;
  logic [PHASE_W-1:0]   sample_cycles_i        = 8'h14;
  logic [PHASE_W-1:0]   settle_cycles_i        = 8'h0A;
  logic                 result_read_i          = 1'b0;
  logic                 irq_clear_i            = 1'b0;
  logic [TIMER_W-1:0]   first_timer_i          = 16'h0000;
  logic                 comparator_i;
  logic                 busy_o;
  logic                 irq_o;
  sarseq_analog_t       analog_o;
  sarseq_result_t       result_o;
  logic [CHAN_W-1:0]    channel_select_field_o;
  logic [TIMER_W-1:0]   timer_capture_o;
  logic signed [11:0]   vin [NUM_CHAN];
  int                   seed                   = 85504;
  int                   fails                  = 0;
  int                   check_count            = 0;
  int                   cyc                    = 0;
  int                   trk_len                = 0;
  int                   busy_len               = 0;
  int                   samp_exp               = 20;
  int                   set_exp                = 10;
  logic                 trk_prev               = 1'b0;
  logic                 ref_exp                = 1'b0;

  sarseq_top i_sarseq_top (
    .clk_i(clk_i), .rst_i(rst_i), .start_wr_i(start_wr_i), .pwm_trigger_i(pwm_trigger_i),
    .converter_enable_bit_i(converter_enable_bit_i),
    .reference_enable_bit_i(reference_enable_bit_i),
    .convert_on_read_bit_i(convert_on_read_bit_i), .channel_wr_i(channel_wr_i),
    .channel_data_i(channel_data_i), .max_channel_i(max_channel_i),
    .sample_cycles_i(sample_cycles_i), .settle_cycles_i(settle_cycles_i),
    .result_read_i(result_read_i), .irq_clear_i(irq_clear_i), .first_timer_i(first_timer_i),
    .comparator_i(comparator_i), .busy_o(busy_o), .irq_o(irq_o), .analog_o(analog_o),
    .result_o(result_o), .channel_select_field_o(channel_select_field_o),
    .timer_capture_o(timer_capture_o));

  sarseq_core_model i_sarseq_core_model (.clk_i(clk_i), .analog_i(analog_o), .vin_i(vin),
    .comparator_o(comparator_i));

  always #25 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    first_timer_i <= first_timer_i + 16'h1;
    cyc++;
    if (cyc == 30000) begin
      fails++;
      stop_test();
    end
  end

  // phase lengths and capture seen from the analog side
  always @(negedge clk_i) begin
    if (rst_i) begin
      trk_len = 0;
    end else begin
      if (analog_o.track) begin
        trk_len++;
        busy_len = 0;
      end else if (busy_o) begin
        busy_len++;
      end
      if (trk_prev && !analog_o.track) begin
        `CHK("sample_len", samp_exp, trk_len)
        `CHK("capture", 16'(first_timer_i - 16'h1), timer_capture_o)
        trk_len = 0;
      end
    end
    trk_prev = analog_o.track;
  end

  function automatic logic [9:0] expect_code(input int v);
    if (v < 0) return 10'h000;
    if (v > 32'sh3FF) return 10'h3FF;
    return 10'(v);
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic setup(input logic [3:0] ch);
    logic [7:0] s;
    logic [7:0] t;
    s = 8'($random(seed)) & 8'h3F;
    t = 8'($random(seed)) & 8'h1F;
    samp_exp = (s < 8'h14) ? 20 : int'(s);
    set_exp = (t < 8'h0A) ? 10 : int'(t);
    ref_exp = 1'($random(seed));
    @(posedge clk_i);
    channel_wr_i <= 1'b1;
    channel_data_i <= ch;
    sample_cycles_i <= s;
    settle_cycles_i <= t;
    reference_enable_bit_i <= ref_exp;
    @(posedge clk_i);
    channel_wr_i <= 1'b0;
  endtask

  task automatic kick(input int kind);
    @(posedge clk_i);
    start_wr_i <= (kind == 0);
    pwm_trigger_i <= (kind == 1);
    result_read_i <= (kind == 2);
    @(posedge clk_i);
    start_wr_i <= 1'b0;
    pwm_trigger_i <= 1'b0;
    result_read_i <= 1'b0;
  endtask

  task automatic go(input int kind, input logic [3:0] ch);
    int n;
    n = 0;
    kick(kind);
    @(negedge clk_i);
    `CHK("busy", 1'b1, busy_o)
    `CHK("mux_en", ch < 4'hC, analog_o.mux_en)
    `CHK("mux_sel", ch, analog_o.mux_sel)
    `CHK("chan_field", ch, channel_select_field_o)
    `CHK("ref_buf", ref_exp, analog_o.ref_buf_en)
    `CHK("core_en", 1'b1, analog_o.core_en)
    while (busy_o !== 1'b0 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("conv_len", 1'b1, busy_len >= set_exp + 68 && busy_len <= set_exp + 73)
    `CHK("irq", 1'b1, irq_o)
    `CHK("res_chan", ch, result_o.channel)
    if (ch < 4'hC) `CHK("res_val", expect_code(vin[ch]), result_o.value)
  endtask

  task automatic clear_irq;
    @(posedge clk_i);
    irq_clear_i <= 1'b1;
    @(posedge clk_i);
    irq_clear_i <= 1'b0;
    @(negedge clk_i);
    `CHK("irq_clr", 1'b0, irq_o)
  endtask

  initial begin
    logic [3:0] c;
    logic [3:0] m;
    first_timer_i = 16'($random(seed));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK("rst_busy", 1'b0, busy_o)
    `CHK("rst_irq", 1'b0, irq_o)
    `CHK("rst_field", CHAN_RST, channel_select_field_o)
    for (int i = 0; i < 12; i++) begin
      c = 4'($unsigned($random(seed)) % 14);
      foreach (vin[k]) vin[k] = 12'(($random(seed) % 600) + 500);
      setup(c);
      go(i % 2, c);
      clear_irq();
    end
    setup(4'h3);
    kick(0);
    repeat (samp_exp + set_exp + 20) @(posedge clk_i);
    setup(4'h5);
    go(0, 4'h5);
    clear_irq();
    @(posedge clk_i);
    pwm_trigger_i <= 1'b1;
    repeat (300) @(posedge clk_i);
    pwm_trigger_i <= 1'b0;
    @(negedge clk_i);
    `CHK("trig_hold", 1'b0, busy_o)
    clear_irq();
    setup(4'h2);
    go(0, 4'h2);
    @(posedge clk_i);
    converter_enable_bit_i <= 1'b0;
    kick(0);
    kick(1);
    @(negedge clk_i);
    `CHK("dis_busy", 1'b0, busy_o)
    `CHK("dis_irq", 1'b1, irq_o)
    `CHK("dis_core", 1'b0, analog_o.core_en)
    @(posedge clk_i);
    converter_enable_bit_i <= 1'b1;
    clear_irq();
    m = 4'($unsigned($random(seed)) % 11) + 4'h1;
    @(posedge clk_i);
    convert_on_read_bit_i <= 1'b1;
    max_channel_i <= m;
    setup(m - 4'h1);
    go(0, m - 4'h1);
    go(2, m);
    go(2, 4'h0);
    repeat (100) @(posedge clk_i);
    @(negedge clk_i);
    `CHK("no_read", 1'b0, busy_o)
    @(posedge clk_i);
    convert_on_read_bit_i <= 1'b0;
    kick(2);
    @(negedge clk_i);
    `CHK("cvt_off", 1'b0, busy_o)
    stop_test();
  end
endmodule
`default_nettype wire

// [rtl/sarseq_pkg.sv]
// constants and types for the successive-approximation converter sequencer
`default_nettype none
package sarseq_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned SAMPLE_MIN_NS = 1000;
  localparam int unsigned SETTLE_MIN_NS = 500;
  localparam int unsigned SAMPLE_MIN_CYC =
    (SAMPLE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SETTLE_MIN_CYC =
    (SETTLE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CONV_DIV   = 6;
  localparam int unsigned CONV_STEPS = 12;
  localparam int unsigned RESULT_W   = 10;
  localparam int unsigned CHAN_W     = 4;
  localparam int unsigned NUM_CHAN   = 12;
  localparam int unsigned TIMER_W    = 16;
  localparam int unsigned PHASE_W    = 8;
  localparam int unsigned DIV_W      = 3;
  localparam int unsigned STEP_W     = 4;
  localparam logic [CHAN_W-1:0]   CHAN_RST    = 4'h0;
  localparam logic [RESULT_W-1:0] RESULT_RST  = 10'h000;
  localparam logic [RESULT_W-1:0] TRIAL_FIRST = 10'h200;
  localparam logic [TIMER_W-1:0]  CAPTURE_RST = 16'h0000;

  typedef enum logic [1:0] {
    SARSEQ_IDLE,
    SARSEQ_SAMPLE,
    SARSEQ_SETTLE,
    SARSEQ_CONVERT
  } sarseq_state_t;

  // drive toward multiplexer, sample-and-hold and DAC core
  typedef struct packed {
    logic                mux_en;
    logic [CHAN_W-1:0]   mux_sel;
    logic                track;
    logic                core_en;
    logic                ref_buf_en;
    logic [RESULT_W-1:0] trial;
  } sarseq_analog_t;

  typedef struct packed {
    logic [RESULT_W-1:0] value;
    logic [CHAN_W-1:0]   channel;
  } sarseq_result_t;
endpackage
`default_nettype wire

// [rtl/sarseq_sar.sv]
// successive-approximation register stepping one bit per conversion clock
`timescale 1ns/1ps
`default_nettype none
module sarseq_sar (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              run_i,
  input  wire logic                              tick_i,
  input  wire logic                              cmp_i,
  output logic        [sarseq_pkg::RESULT_W-1:0] trial_o,
  output logic        [sarseq_pkg::RESULT_W-1:0] result_o,
  output logic                                   done_o
);
  import sarseq_pkg::*;

  logic [STEP_W-1:0]   step_reg,   step_next;
  logic [RESULT_W-1:0] trial_reg,  trial_next;
  logic [RESULT_W-1:0] result_reg, result_next;
  logic                done_reg,   done_next;

  always_comb begin
    step_next   = step_reg;
    trial_next  = trial_reg;
    result_next = result_reg;
    done_next   = 1'b0;
    if (!run_i) begin
      step_next  = '0;
      trial_next = '0;
    end else if (tick_i) begin
      // twelve steps: set msb, resolve ten bits, deliver
      step_next = step_reg + 4'h1;
      if (step_reg == 4'h0) begin
        trial_next = TRIAL_FIRST;
      end else if (step_reg <= 4'(RESULT_W)) begin
        // keep or drop current bit, try the next lower one
        for (int b = 0; b < RESULT_W; b++) begin
          if (b == RESULT_W - int'(step_reg)) begin
            trial_next[b] = cmp_i;
            if (b > 0) begin
              trial_next[b-1] = 1'b1;
            end
          end
        end
      end else if (step_reg == 4'(CONV_STEPS - 1)) begin
        result_next = trial_reg;
        done_next   = 1'b1;
        step_next   = '0;
        trial_next  = '0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_reg   <= '0;
      trial_reg  <= '0;
      result_reg <= RESULT_RST;
      done_reg   <= 1'b0;
    end else begin
      step_reg   <= step_next;
      trial_reg  <= trial_next;
      result_reg <= result_next;
      done_reg   <= done_next;
    end
  end

  assign trial_o  = trial_reg;
  assign result_o = result_reg;
  assign done_o   = done_reg;
endmodule
`default_nettype wire

// [rtl/sarseq_top.sv]
// converter sequencer: start, sampling, settling, conversion and capture
`timescale 1ns/1ps
`default_nettype none
module sarseq_top (
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  input  wire logic                               start_wr_i,
  input  wire logic                               pwm_trigger_i,
  input  wire logic                               converter_enable_bit_i,
  input  wire logic                               reference_enable_bit_i,
  input  wire logic                               convert_on_read_bit_i,
  input  wire logic                               channel_wr_i,
  input  wire logic        [sarseq_pkg::CHAN_W-1:0]  channel_data_i,
  input  wire logic        [sarseq_pkg::CHAN_W-1:0]  max_channel_i,
  input  wire logic        [sarseq_pkg::PHASE_W-1:0] sample_cycles_i,
  input  wire logic        [sarseq_pkg::PHASE_W-1:0] settle_cycles_i,
  input  wire logic                               result_read_i,
  input  wire logic                               irq_clear_i,
  input  wire logic        [sarseq_pkg::TIMER_W-1:0] first_timer_i,
  input  wire logic                               comparator_i,
  output logic                                    busy_o,
  output logic                                    irq_o,
  output sarseq_pkg::sarseq_analog_t              analog_o,
  output sarseq_pkg::sarseq_result_t              result_o,
  output logic             [sarseq_pkg::CHAN_W-1:0]  channel_select_field_o,
  output logic             [sarseq_pkg::TIMER_W-1:0] timer_capture_o
);
  import sarseq_pkg::*;

  function automatic logic chan_valid(input logic [CHAN_W-1:0] c);
    return c < 4'(NUM_CHAN);
  endfunction

  sarseq_state_t       state_reg,   state_next;
  logic [PHASE_W-1:0]  cnt_reg,     cnt_next;
  logic [DIV_W-1:0]    div_reg,     div_next;
  logic [CHAN_W-1:0]   chan_reg,    chan_next;
  logic [TIMER_W-1:0]  cap_reg,     cap_next;
  logic                trig_reg,    busy_reg,  busy_next;
  logic                irq_reg,     irq_next;
  logic [2:0]          cmp_sync_reg;
  logic                cmp_reg,     cmp_next;
  sarseq_analog_t      ana_reg,     ana_next;
  sarseq_result_t      res_reg,     res_next;
  logic                tick, trig_pulse, cor_read, start_any, sample_end, settle_end;
  logic [PHASE_W-1:0]  samp_len, sett_len;
  logic [RESULT_W-1:0] sar_trial, sar_result;
  logic                sar_done;

  sarseq_sar u_sar (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .run_i    (state_reg == SARSEQ_CONVERT),
    .tick_i   (tick),
    .cmp_i    (cmp_reg),
    .trial_o  (sar_trial),
    .result_o (sar_result),
    .done_o   (sar_done)
  );

  always_comb begin
    tick       = (div_reg == 3'(CONV_DIV - 1));
    div_next   = tick ? '0 : div_reg + 3'h1;
    trig_pulse = pwm_trigger_i && !trig_reg;
    cor_read   = result_read_i && convert_on_read_bit_i;
    // only a written one, a trigger edge or a read with convert-on-read set starts; disabled ignores all
    start_any  = converter_enable_bit_i && (start_wr_i || trig_pulse || cor_read);
    samp_len   = (sample_cycles_i < 8'(SAMPLE_MIN_CYC)) ? 8'(SAMPLE_MIN_CYC)
                                                         : sample_cycles_i;
    sett_len   = (settle_cycles_i < 8'(SETTLE_MIN_CYC)) ? 8'(SETTLE_MIN_CYC)
                                                         : settle_cycles_i;
    sample_end = (state_reg == SARSEQ_SAMPLE) && (cnt_reg + 8'h1 >= samp_len);
    settle_end = (state_reg == SARSEQ_SETTLE) && (cnt_reg + 8'h1 >= sett_len);
    // comparator decision taken once the last two sync stages agree
    cmp_next   = (cmp_sync_reg[1] == cmp_sync_reg[2]) ? cmp_sync_reg[2] : cmp_reg;
  end

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 8'h1;
    chan_next  = chan_reg;
    cap_next   = cap_reg;
    res_next   = res_reg;
    irq_next   = irq_reg;
    if (channel_wr_i) begin
      chan_next = channel_data_i;
    end else if (cor_read && converter_enable_bit_i) begin
      chan_next = (chan_reg == max_channel_i) ? '0 : chan_reg + 4'h1;
    end
    if (!converter_enable_bit_i) begin
      state_next = SARSEQ_IDLE;
      cnt_next   = '0;
    end else if (start_any) begin
      state_next = SARSEQ_SAMPLE;
      cnt_next   = '0;
    end else begin
      unique case (state_reg)
        SARSEQ_IDLE: begin
          cnt_next = '0;
        end
        SARSEQ_SAMPLE: begin
          if (sample_end) begin
            state_next = SARSEQ_SETTLE;
            cnt_next   = '0;
            cap_next   = first_timer_i;
          end
        end
        SARSEQ_SETTLE: begin
          if (settle_end) begin
            state_next = SARSEQ_CONVERT;
            cnt_next   = '0;
          end
        end
        SARSEQ_CONVERT: begin
          cnt_next = '0;
          if (sar_done) begin
            state_next    = SARSEQ_IDLE;
            res_next.value   = sar_result;
            res_next.channel = ana_reg.mux_sel;
          end
        end
      endcase
    end
    // set wins over clear; disable leaves it alone
    if (irq_clear_i) begin
      irq_next = 1'b0;
    end
    if (state_reg == SARSEQ_CONVERT && sar_done) begin
      irq_next = 1'b1;
    end
    busy_next = (state_next != SARSEQ_IDLE);
    ana_next            = ana_reg;
    ana_next.core_en    = converter_enable_bit_i;
    ana_next.ref_buf_en = reference_enable_bit_i;
    ana_next.track      = (state_next == SARSEQ_SAMPLE);
    ana_next.trial      = sar_trial;
    if (start_any) begin
      ana_next.mux_sel = chan_next;
      ana_next.mux_en  = chan_valid(chan_next);
    end else if (state_next == SARSEQ_IDLE) begin
      ana_next.mux_en  = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg    <= SARSEQ_IDLE;
      cnt_reg      <= '0;
      div_reg      <= '0;
      chan_reg     <= CHAN_RST;
      cap_reg      <= CAPTURE_RST;
      trig_reg     <= 1'b0;
      busy_reg     <= 1'b0;
      irq_reg      <= 1'b0;
      cmp_sync_reg <= '0;
      cmp_reg      <= 1'b0;
      ana_reg      <= '0;
      res_reg      <= '0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      div_reg      <= div_next;
      chan_reg     <= chan_next;
      cap_reg      <= cap_next;
      trig_reg     <= pwm_trigger_i;
      busy_reg     <= busy_next;
      irq_reg      <= irq_next;
      cmp_sync_reg <= {cmp_sync_reg[1:0], comparator_i};
      cmp_reg      <= cmp_next;
      ana_reg      <= ana_next;
      res_reg      <= res_next;
    end
  end

  assign busy_o                 = busy_reg;
  assign irq_o                  = irq_reg;
  assign analog_o               = ana_reg;
  assign result_o               = res_reg;
  assign channel_select_field_o = chan_reg;
  assign timer_capture_o        = cap_reg;

  // checks
  localparam int CONV_LO = int'((CONV_STEPS - 1) * CONV_DIV) + 2;
  localparam int CONV_HI = int'(CONV_STEPS * CONV_DIV) + 1;
  logic [7:0] conv_cnt_reg;
  logic [7:0] samp_cnt_reg;
  logic [7:0] sett_cnt_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_cnt_reg <= '0;
      samp_cnt_reg <= '0;
      sett_cnt_reg <= '0;
    end else begin
      conv_cnt_reg <= (state_reg == SARSEQ_CONVERT) ? conv_cnt_reg + 8'h1 : 8'h0;
      // consecutive cycles per phase, apart from the phase counter
      samp_cnt_reg <= (state_reg != SARSEQ_SAMPLE) ? 8'h00
                    : (samp_cnt_reg == 8'hFF) ? 8'hFF : samp_cnt_reg + 8'h1;
      sett_cnt_reg <= (state_reg != SARSEQ_SETTLE) ? 8'h00
                    : (sett_cnt_reg == 8'hFF) ? 8'hFF : sett_cnt_reg + 8'h1;
    end
  end

  sequence s_sample_done;
    (state_reg == SARSEQ_SAMPLE) ##1 (state_reg == SARSEQ_SETTLE);
  endsequence

  AST_BUSY_ON_START: assert property (@(posedge clk_i) disable iff (rst_i)
    start_any |=> busy_o) else $error("busy not set after start");
  AST_NO_SPURIOUS: assert property (@(posedge clk_i) disable iff (rst_i)
    (!busy_o && state_reg == SARSEQ_IDLE && !start_any) |=> !busy_o)
    else $error("busy without start");
  AST_SAMPLE_MIN: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SARSEQ_SAMPLE && state_next == SARSEQ_SETTLE)
      |-> (samp_cnt_reg >= 8'(SAMPLE_MIN_CYC - 1)))
    else $error("sampling too short");
  AST_SETTLE_MIN: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SARSEQ_SETTLE && state_next == SARSEQ_CONVERT)
      |-> (sett_cnt_reg >= 8'(SETTLE_MIN_CYC - 1)))
    else $error("settling too short");
  AST_CONV_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SARSEQ_CONVERT && sar_done)
      |-> (conv_cnt_reg >= 8'(CONV_LO - 1) && conv_cnt_reg <= 8'(CONV_HI - 1)))
    else $error("conversion length wrong");
  AST_IRQ_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SARSEQ_CONVERT && sar_done) |=> irq_o ##1 (irq_o || $past(irq_clear_i)))
    else $error("completion irq missing");
  AST_IRQ_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (irq_o && !irq_clear_i) |=> irq_o) else $error("irq dropped without clear");
  AST_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_sample_done |-> (timer_capture_o == $past(first_timer_i)))
    else $error("timer capture wrong");
  AST_COR_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
    (cor_read && converter_enable_bit_i && !channel_wr_i
      && channel_select_field_o == max_channel_i) |=> (channel_select_field_o == '0))
    else $error("channel did not wrap");
  AST_DISABLED: assert property (@(posedge clk_i) disable iff (rst_i)
    !converter_enable_bit_i |=> (!busy_o && !analog_o.core_en))
    else $error("active while disabled");
  AST_REF_BUF: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (analog_o.ref_buf_en == $past(reference_enable_bit_i)))
    else $error("reference buffer not following");
  AST_RESERVED: assert property (@(posedge clk_i) disable iff (rst_i)
    analog_o.mux_en |-> chan_valid(analog_o.mux_sel)) else $error("reserved channel used");
endmodule
`default_nettype wire
